// file: src/cpl_device.sv
// Palette device end: host register port, 256 x 18 table, pixel lookup.
// Assumes strobes, selects and pixel pins are synchronous to clk and the
// pixel clock is slower than half of clk so each of its edges is seen.
`timescale 1ns/1ps

// Behaviour
// - Selects pick pointer write, pointer read, palette, mask
// - Eight-bit pointer indexes palette for host
// - Pointer write loads index, clears colour phase
// - Pointer read leaves pointer and phase alone
// - Blue write stores joined 18-bit entry
// - Pointer advances after blue write
// - Three reads return red, green, blue
// - Colour on bits 5..0, upper bits zero
// - Pointer wraps to zero after last entry
// - Hidden phase counts red, green, blue modulo three
// - Table transfers happen between host accesses
// - Host prefers loading colours during blanking
// - Pixel index latched on pixel clock rise
// - Blank latched on same pixel clock edge
// - Pixel index ANDed with read mask
// - Host reads and writes mask anytime
// - Write data taken at strobe rising edge
// - Low blank forces blanking level outputs
module cpl_device (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  cpl_if.dev                               bus,
  output logic [cpl_pkg::COMP_W-1:0]       red_level,
  output logic [cpl_pkg::COMP_W-1:0]       green_level,
  output logic [cpl_pkg::COMP_W-1:0]       blue_level,
  output logic                             blank_level_n
);
  import cpl_pkg::*;

  function automatic logic [COMP_W-1:0] comp_of(
    input logic [ENTRY_W-1:0] entry,
    input cpl_phase_t         ph
  );
    logic [COMP_W-1:0] c;
    c = entry[BLUE_LSB +: COMP_W];
    unique case (ph)
      PH_RED:   c = entry[RED_LSB +: COMP_W];
      PH_GREEN: c = entry[GREEN_LSB +: COMP_W];
      PH_BLUE:  c = entry[BLUE_LSB +: COMP_W];
      default:  c = entry[BLUE_LSB +: COMP_W];
    endcase
    return c;
  endfunction

  logic [ENTRY_W-1:0] palette_mem [PAL_DEPTH];

  logic [IDX_W-1:0]   ptr_q;
  logic [IDX_W-1:0]   ptr_d;
  cpl_phase_t         phase_q;
  cpl_phase_t         phase_d;
  logic [IDX_W-1:0]   mask_q;
  logic [COMP_W-1:0]  red_stage_q;
  logic [COMP_W-1:0]  green_stage_q;
  logic [IDX_W-1:0]   data_q;
  logic               wr_prev_q;
  logic               rd_prev_q;
  logic               bad_q;
  logic [IDX_W-1:0]   dout_q;
  logic               oe_n_q;
  logic               pclk_prev_q;
  logic [IDX_W-1:0]   pix_q;
  logic               blank_q;
  logic [COMP_W-1:0]  red_q;
  logic [COMP_W-1:0]  green_q;
  logic [COMP_W-1:0]  blue_q;
  logic               blank_out_q;

  // Decode of the host access
  wire [1:0]          sel        = {bus.register_select1, bus.register_select0};
  wire                both_low   = !bus.rd_n && !bus.wr_n;
  wire                both_high  = bus.rd_n && bus.wr_n;
  wire                rd_active  = !bus.rd_n && bus.wr_n;
  // A strobe that overlapped the other one is dropped at its release
  wire                wr_done    = !wr_prev_q && bus.wr_n && !bad_q;
  wire                rd_done    = !rd_prev_q && bus.rd_n && !bad_q;
  wire                pal_sel    = (sel == SEL_PAL);
  wire                ptr_load   = wr_done && ((sel == SEL_PTR_WR) ||
                                               (sel == SEL_PTR_RD));
  wire                mask_load  = wr_done && (sel == SEL_MASK);
  wire                pal_step   = pal_sel && (wr_done || rd_done);
  wire                blue_step  = pal_step && (phase_q == PH_BLUE);
  wire                blue_write = wr_done && pal_sel && (phase_q == PH_BLUE);
  wire [ENTRY_W-1:0]  host_entry = palette_mem[ptr_q];
  wire [ENTRY_W-1:0]  new_entry  = {red_stage_q, green_stage_q,
                                    data_q[COMP_W-1:0]};
  wire [ENTRY_W-1:0]  pix_entry  = palette_mem[pix_q];
  wire                pclk_rise  = bus.pclk && !pclk_prev_q;

  // Read data: colours are right justified with zero padding
  logic [IDX_W-1:0]   read_word;
  always_comb begin
    read_word = ptr_q;
    unique case (sel)
      SEL_PAL:  read_word = {PAD_ZERO, comp_of(host_entry, phase_q)};
      SEL_MASK: read_word = mask_q;
      default:  read_word = ptr_q;
    endcase
  end

  // Phase counter and pointer next values
  always_comb begin
    phase_d = phase_q;
    ptr_d   = ptr_q;
    if (ptr_load) begin
      phase_d = PH_RED;
      ptr_d   = data_q;
    end else if (pal_step) begin
      unique case (phase_q)
        PH_RED:   phase_d = PH_GREEN;
        PH_GREEN: phase_d = PH_BLUE;
        default:  phase_d = PH_RED;
      endcase
      // Eight-bit add rolls the last entry over to zero
      if (blue_step) begin
        ptr_d = ptr_q + 8'h01;
      end
    end
  end

  // Strobe tracking and write data capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
      bad_q     <= 1'b0;
      data_q    <= PTR_RST;
    end else begin
      wr_prev_q <= bus.wr_n;
      rd_prev_q <= bus.rd_n;
      if (both_low) begin
        bad_q <= 1'b1;
      end else if (both_high) begin
        bad_q <= 1'b0;
      end
      if (!bus.wr_n) begin
        data_q <= bus.host_data_bus;
      end
    end
  end

  // Host visible registers and colour staging
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q         <= PTR_RST;
      phase_q       <= PH_RED;
      mask_q        <= MASK_RST;
      red_stage_q   <= BLANK_LEVEL;
      green_stage_q <= BLANK_LEVEL;
    end else begin
      ptr_q   <= ptr_d;
      phase_q <= phase_d;
      if (mask_load) begin
        mask_q <= data_q;
      end
      if (wr_done && pal_sel && (phase_q == PH_RED)) begin
        red_stage_q <= data_q[COMP_W-1:0];
      end
      if (wr_done && pal_sel && (phase_q == PH_GREEN)) begin
        green_stage_q <= data_q[COMP_W-1:0];
      end
    end
  end

  // Table write lands at strobe release, before the next access can start
  always_ff @(posedge clk) begin
    if (blue_write) begin
      palette_mem[ptr_q] <= new_entry;
    end
  end

  // Read driver: data follows the live pointer and phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= PTR_RST;
      oe_n_q <= 1'b1;
    end else begin
      dout_q <= read_word;
      oe_n_q <= !rd_active;
    end
  end

  // Pixel port: latch, mask, look up, blank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_prev_q <= 1'b0;
      pix_q       <= PTR_RST;
      blank_q     <= 1'b0;
      red_q       <= BLANK_LEVEL;
      green_q     <= BLANK_LEVEL;
      blue_q      <= BLANK_LEVEL;
      blank_out_q <= 1'b0;
    end else begin
      pclk_prev_q <= bus.pclk;
      if (pclk_rise) begin
        pix_q   <= bus.pixel_index_inputs & mask_q;
        blank_q <= bus.blank_n;
      end
      blank_out_q <= blank_q;
      if (blank_q) begin
        red_q   <= comp_of(pix_entry, PH_RED);
        green_q <= comp_of(pix_entry, PH_GREEN);
        blue_q  <= comp_of(pix_entry, PH_BLUE);
      end else begin
        red_q   <= BLANK_LEVEL;
        green_q <= BLANK_LEVEL;
        blue_q  <= BLANK_LEVEL;
      end
    end
  end

  assign bus.dev_d_o    = dout_q;
  assign bus.dev_d_oe_n = oe_n_q;
  assign red_level      = red_q;
  assign green_level    = green_q;
  assign blue_level     = blue_q;
  assign blank_level_n  = blank_out_q;

endmodule

// file: src/cpl_pkg.sv
// Constants shared by both ends of the palette lookup port.
// Assumes one 100 MHz system clock; all pins are sampled on it.
package cpl_pkg;
  localparam int          CLK_MHZ      = 100;
  localparam int          IDX_W        = 8;
  localparam int          COMP_W       = 6;
  localparam int          ENTRY_W      = 18;
  localparam int          PAL_DEPTH    = 256;
  localparam int          RED_LSB      = 12;
  localparam int          GREEN_LSB    = 6;
  localparam int          BLUE_LSB     = 0;
  // Select codes written as {register_select1, register_select0}
  localparam logic [1:0]  SEL_PTR_WR   = 2'h0;
  localparam logic [1:0]  SEL_PAL      = 2'h1;
  localparam logic [1:0]  SEL_MASK     = 2'h2;
  localparam logic [1:0]  SEL_PTR_RD   = 2'h3;
  localparam logic [7:0]  PTR_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST     = 8'hff;
  localparam logic [5:0]  BLANK_LEVEL  = 6'h00;
  localparam logic [1:0]  PAD_ZERO     = 2'h0;
  localparam logic [7:0]  BUS_IDLE     = 8'h00;
  // Host timing in system clock cycles
  localparam logic [3:0]  STROBE_CYC   = 4'h4;
  localparam logic [3:0]  RECOVER_CYC  = 4'h2;
  localparam logic [3:0]  PCLK_DIV     = 4'h4;
  localparam logic [3:0]  PCLK_HALF    = 4'h2;
  localparam logic [3:0]  CNT_ONE      = 4'h1;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;

  typedef enum logic [1:0] {PH_RED, PH_GREEN, PH_BLUE} cpl_phase_t;
  typedef enum logic [1:0] {HS_IDLE, HS_STROBE, HS_RECOVER} cpl_hstate_t;
endpackage

// file: src/cpl_if.sv
// Pins between the host/frame-buffer controller and the palette device.
// Assumes both ends run on the same clock; data bus resolved here.
`timescale 1ns/1ps
interface cpl_if;
  logic       rd_n;
  logic       wr_n;
  logic       register_select0;
  logic       register_select1;
  logic [7:0] host_d_o;
  logic       host_d_oe_n;
  logic [7:0] dev_d_o;
  logic       dev_d_oe_n;
  logic [7:0] host_data_bus;
  logic       pclk;
  logic       blank_n;
  logic [7:0] pixel_index_inputs;

  // Device wins if both drive; idle bus reads as zero
  assign host_data_bus = !dev_d_oe_n  ? dev_d_o  :
                         !host_d_oe_n ? host_d_o : 8'h00;

  modport dev (
    input  rd_n, wr_n, register_select0, register_select1, host_data_bus,
    input  pclk, blank_n, pixel_index_inputs,
    output dev_d_o, dev_d_oe_n
  );
  modport host (
    output rd_n, wr_n, register_select0, register_select1, host_d_o, host_d_oe_n,
    output pclk, blank_n, pixel_index_inputs,
    input  host_data_bus
  );
endinterface

// file: src/cpl_host.sv
// Host end: turns user requests into strobed bus cycles and drives pixels.
// Assumes the device end shares clk; pixel clock comes from a divider.
`timescale 1ns/1ps
module cpl_host (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  cpl_if.host                              bus,
  input  wire logic                        req_valid,
  input  wire logic                        req_write,
  input  wire logic [1:0]                  req_sel,
  input  wire logic [cpl_pkg::IDX_W-1:0]   req_wdata,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [cpl_pkg::IDX_W-1:0]        rsp_data,
  input  wire logic [cpl_pkg::IDX_W-1:0]   pix_index_in,
  input  wire logic                        pix_blank_n_in
);
  import cpl_pkg::*;

  cpl_hstate_t       st_q;
  logic [3:0]        cnt_q;
  logic              is_wr_q;
  logic              rd_n_q;
  logic              wr_n_q;
  logic [1:0]        sel_q;
  logic [IDX_W-1:0]  d_o_q;
  logic              d_oe_n_q;
  logic              ready_q;
  logic              rsp_valid_q;
  logic [IDX_W-1:0]  rsp_data_q;
  logic [3:0]        pdiv_q;
  logic              pclk_q;
  logic [IDX_W-1:0]  pix_q;
  logic              blank_q;

  wire               take     = ready_q && req_valid;
  wire               last_cnt = (cnt_q == CNT_ONE);
  wire               pdiv_end = (pdiv_q == PCLK_DIV - CNT_ONE);

  // Only one strobe is ever low at a time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= HS_IDLE;
      cnt_q       <= CNT_ZERO;
      is_wr_q     <= 1'b0;
      rd_n_q      <= 1'b1;
      wr_n_q      <= 1'b1;
      sel_q       <= SEL_PTR_WR;
      d_o_q       <= BUS_IDLE;
      d_oe_n_q    <= 1'b1;
      ready_q     <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= BUS_IDLE;
    end else begin
      rsp_valid_q <= 1'b0;
      unique case (st_q)
        HS_IDLE: if (take) begin
          st_q     <= HS_STROBE;
          cnt_q    <= STROBE_CYC;
          is_wr_q  <= req_write;
          sel_q    <= req_sel;
          d_o_q    <= req_wdata;
          d_oe_n_q <= !req_write;
          wr_n_q   <= !req_write;
          rd_n_q   <= req_write;
          ready_q  <= 1'b0;
        end
        HS_STROBE: begin
          cnt_q <= cnt_q - CNT_ONE;
          if (last_cnt) begin
            st_q     <= HS_RECOVER;
            cnt_q    <= RECOVER_CYC;
            wr_n_q   <= 1'b1;
            rd_n_q   <= 1'b1;
            d_oe_n_q <= 1'b1;
            if (!is_wr_q) begin
              rsp_valid_q <= 1'b1;
              rsp_data_q  <= bus.host_data_bus;
            end
          end
        end
        HS_RECOVER: begin
          cnt_q <= cnt_q - CNT_ONE;
          if (last_cnt) begin
            st_q    <= HS_IDLE;
            ready_q <= 1'b1;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Pixel clock divider; index changes on the falling half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pdiv_q  <= CNT_ZERO;
      pclk_q  <= 1'b0;
      pix_q   <= BUS_IDLE;
      blank_q <= 1'b0;
    end else begin
      pdiv_q <= pdiv_end ? CNT_ZERO : pdiv_q + CNT_ONE;
      if (pdiv_q == CNT_ZERO) begin
        pclk_q  <= 1'b0;
        pix_q   <= pix_index_in;
        blank_q <= pix_blank_n_in;
      end else if (pdiv_q == PCLK_HALF) begin
        pclk_q <= 1'b1;
      end
    end
  end

  assign bus.rd_n               = rd_n_q;
  assign bus.wr_n               = wr_n_q;
  assign bus.register_select0   = sel_q[0];
  assign bus.register_select1   = sel_q[1];
  assign bus.host_d_o           = d_o_q;
  assign bus.host_d_oe_n        = d_oe_n_q;
  assign bus.pclk               = pclk_q;
  assign bus.blank_n            = blank_q;
  assign bus.pixel_index_inputs = pix_q;
  assign req_ready              = ready_q;
  assign rsp_valid              = rsp_valid_q;
  assign rsp_data               = rsp_data_q;
endmodule

// file: tb/cpl_props.sv
// Interface-level checks for the palette port, both ends being design code.
// Assumes one clock for both ends and the interface signals as plain inputs.
`timescale 1ns/1ps
module cpl_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       register_select0,
  input wire logic       register_select1,
  input wire logic [7:0] host_d_o,
  input wire logic       host_d_oe_n,
  input wire logic [7:0] dev_d_o,
  input wire logic       dev_d_oe_n,
  input wire logic       pclk,
  input wire logic       blank_n,
  input wire logic [7:0] pixel_index_inputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  strobe_excl_a: assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  read_drive_a: assert property ($fell(rd_n) |=> !dev_d_oe_n)
    else $error("device did not drive read data one cycle after strobe");
  read_release_a: assert property ($rose(rd_n) |=> dev_d_oe_n)
    else $error("device kept driving bus after read strobe");
  host_quiet_a: assert property (!rd_n |-> host_d_oe_n)
    else $error("host drives bus during read");
  wr_quiet_a: assert property (!wr_n |-> dev_d_oe_n)
    else $error("device drives bus during write");
  wr_width_a: assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
    else $error("write strobe width wrong");
  wr_hold_a: assert property (!wr_n && !$fell(wr_n) |->
    $stable({register_select1, register_select0, host_d_o}) && !host_d_oe_n)
    else $error("write select or data moved while strobe low");
  pad_zero_a: assert property (!rd_n && !dev_d_oe_n &&
    {register_select1, register_select0} == cpl_pkg::SEL_PAL |-> dev_d_o[7:6] == 2'h0)
    else $error("upper bits of colour read not zero");
  pclk_period_a: assert property ($rose(pclk) |=> !$rose(pclk) [*3] ##1 $rose(pclk))
    else $error("pixel clock period not four cycles");
  pix_setup_a: assert property ($rose(pclk) |-> $stable(pixel_index_inputs) && $stable(blank_n))
    else $error("pixel pins changed at pixel clock rise");
endmodule

// file: tb/cpl_tb.sv
// Self-checking bench: host end and device end joined by the interface.
// Assumes the package constants; a bench model of pointer, phase and table.
`timescale 1ns/1ps
`define CPL_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module cpl_tb;
  import cpl_pkg::*;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                req_valid = 1'b0;
  logic                req_write = 1'b0;
  logic [1:0]          req_sel = 2'h0;
  logic [7:0]          req_wdata = 8'h00;
  logic                req_ready;
  logic                rsp_valid;
  logic [7:0]          rsp_data;
  logic [7:0]          pix_index_in = 8'h00;
  logic                pix_blank_n_in = 1'b1;
  logic [COMP_W-1:0]   red_level;
  logic [COMP_W-1:0]   green_level;
  logic [COMP_W-1:0]   blue_level;
  logic                blank_level_n;
  int                  n_errors = 0;
  int                  num_checks = 0;
  // Bench model of the device state
  logic [ENTRY_W-1:0]  m_mem [PAL_DEPTH];
  logic [5:0]          m_stage [3];
  logic [7:0]          m_ptr = PTR_RST;
  logic [7:0]          m_mask = MASK_RST;
  int                  m_ph = 0;

  always #5 clk = ~clk;

  cpl_if bus_if ();
  cpl_host cpl_host_i (.clk(clk), .rst_n(rst_n), .bus(bus_if.host), .req_valid(req_valid),
    .req_write(req_write), .req_sel(req_sel), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pix_index_in(pix_index_in),
    .pix_blank_n_in(pix_blank_n_in));
  cpl_device cpl_device_i (.clk(clk), .rst_n(rst_n), .bus(bus_if.dev), .red_level(red_level),
    .green_level(green_level), .blue_level(blue_level), .blank_level_n(blank_level_n));
  cpl_props cpl_props_i (.clk(clk), .rst_n(rst_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
    .register_select0(bus_if.register_select0), .register_select1(bus_if.register_select1),
    .host_d_o(bus_if.host_d_o), .host_d_oe_n(bus_if.host_d_oe_n), .dev_d_o(bus_if.dev_d_o),
    .dev_d_oe_n(bus_if.dev_d_oe_n), .pclk(bus_if.pclk), .blank_n(bus_if.blank_n),
    .pixel_index_inputs(bus_if.pixel_index_inputs));

  // Expected read value; advances the model exactly as the device should
  function automatic logic [7:0] model_op(bit wr, logic [1:0] sel, logic [7:0] d);
    logic [7:0]         r;
    logic [ENTRY_W-1:0] t;
    r = 8'h00;
    if (sel == SEL_MASK) begin
      if (wr) m_mask = d;
      else r = m_mask;
    end else if (sel != SEL_PAL) begin
      if (wr) begin
        m_ptr = d;
        m_ph = 0;
      end else r = m_ptr;
    end else begin
      t = m_mem[m_ptr] >> (12 - 6 * m_ph);
      if (wr) m_stage[m_ph] = d[5:0];
      else r = {2'h0, t[5:0]};
      if (m_ph == 2) begin
        if (wr) m_mem[m_ptr] = {m_stage[0], m_stage[1], m_stage[2]};
        m_ptr = m_ptr + 8'h01;
        m_ph = 0;
      end else m_ph++;
    end
    return r;
  endfunction

  // One request through the host end; waits until it is idle again
  task automatic op_chk(input bit wr, input logic [1:0] sel, input logic [7:0] d);
    logic [7:0] exp_v;
    logic [7:0] q;
    int         n;
    exp_v = model_op(wr, sel, d);
    // Unknown until a response arrives, so a lost response cannot match
    q = 8'hxx;
    n = 0;
    @(posedge clk);
    #1;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) n_errors++;
    req_valid = 1'b1;
    req_write = wr;
    req_sel = sel;
    req_wdata = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      if (rsp_valid === 1'b1) q = rsp_data;
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) n_errors++;
    if (!wr) `CPL_CHK(q, exp_v)
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    logic [7:0]         idx;
    logic [ENTRY_W-1:0] e;
    bit                 bl;
    logic [ENTRY_W:0]   got_p;
    logic [ENTRY_W:0]   exp_p;
    void'($urandom(32'h686340c1));
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    op_chk(1'b0, SEL_PTR_RD, 8'h00);
    op_chk(1'b0, SEL_PTR_WR, 8'h00);
    op_chk(1'b0, SEL_MASK, 8'h00);
    // Table is loaded while the display is blanked
    pix_blank_n_in = 1'b0;
    // Fill the whole table; upper data bits set on purpose, they must be dropped
    op_chk(1'b1, SEL_PTR_WR, 8'h00);
    for (int i = 0; i < 3 * PAL_DEPTH; i++) op_chk(1'b1, SEL_PAL, 8'(($urandom)|8'hc0));
    `CPL_CHK({blank_level_n, red_level, green_level, blue_level}, 19'h00000)
    op_chk(1'b0, SEL_PTR_RD, 8'h00);
    // Pointer read in mid-entry must not restart the colour phase
    op_chk(1'b1, SEL_PTR_WR, 8'hfe);
    op_chk(1'b0, SEL_PAL, 8'h00);
    op_chk(1'b0, SEL_PTR_RD, 8'h00);
    for (int i = 0; i < 5; i++) op_chk(1'b0, SEL_PAL, 8'h00);
    op_chk(1'b0, SEL_PTR_RD, 8'h00);
    // Pointer write in mid-entry restarts at red
    op_chk(1'b1, SEL_PTR_WR, 8'h10);
    op_chk(1'b1, SEL_PAL, 8'h2a);
    op_chk(1'b1, SEL_PTR_RD, 8'h20);
    for (int i = 0; i < 3; i++) op_chk(1'b1, SEL_PAL, 8'($urandom));
    op_chk(1'b1, SEL_PTR_WR, 8'h20);
    for (int i = 0; i < 3; i++) op_chk(1'b0, SEL_PAL, 8'h00);
    // Random mix of every select code in both directions
    for (int i = 0; i < 300; i++) op_chk(1'($urandom), 2'($urandom), 8'($urandom));
    // Pixel lookup through a fresh mask, with blanking now and then
    for (int i = 0; i < 40; i++) begin
      op_chk(1'b1, SEL_MASK, (i == 0) ? 8'hff : 8'($urandom));
      idx = 8'($urandom);
      bl = ($urandom % 4) != 0;
      pix_index_in = idx;
      pix_blank_n_in = bl;
      // Held long enough to cover latch and output latency
      repeat (16) @(posedge clk);
      #1;
      e = m_mem[idx & m_mask];
      got_p = {blank_level_n, red_level, green_level, blue_level};
      exp_p = bl ? {1'b1, e} : {1'b0, BLANK_LEVEL, BLANK_LEVEL, BLANK_LEVEL};
      `CPL_CHK(got_p, exp_p)
    end
    give_verdict();
  end
endmodule
